// ---- clrr_result_regs.sv ----
// Result register file for the colour and compensation light channels.
`timescale 1ns/1ps
`include "clrr_params.svh"

module clrr_result_regs
    import clrr_pkg::*;
#(
    parameter int W = 20
)
(
    // Clock and reset
    input  wire logic         clk_sys,
    input  wire logic         rst,
    // Converter results, one pulse per finished conversion set
    input  wire logic         raw_valid,
    input  wire logic [W-1:0] raw_green_value,
    input  wire logic [W-1:0] raw_blue_value,
    input  wire logic [W-1:0] raw_red_value,
    input  wire logic [W-1:0] raw_comp_value,
    // Resolution code: 0 selects 20 bits, 7 selects 13 bits
    input  wire logic [2:0]   resolution_rate_config,
    // Register read port
    input  wire logic         rd_req,
    input  wire logic [7:0]   rd_addr,
    output logic              rd_ack,
    output logic [7:0]        rd_data,
    // Stored results
    output logic [W-1:0]      green_result,
    output logic [W-1:0]      blue_result,
    output logic [W-1:0]      red_result,
    output logic [W-1:0]      temp_comp_result
);

    clrr_result_t   max_val;
    clrr_result_t   stored_max;
    clrr_result_t   green_next;
    clrr_result_t   blue_next;
    clrr_result_t   red_next;
    clrr_result_t   comp_next;
    clrr_result_t   green_reg;
    clrr_result_t   blue_reg;
    clrr_result_t   red_reg;
    clrr_result_t   comp_reg;
    clrr_res_code_t res_code_reg;
    logic [7:0]     rd_data_next;
    logic [7:0]     rd_data_reg;
    logic           rd_ack_reg;

    // Clipping to the full-scale mask keeps bit weights fixed per resolution.
    assign max_val = `CLRR_FULL_ONES >> resolution_rate_config;

    // Mask of the stored set; every bit above it is zero fill in the upper bytes.
    assign stored_max = `CLRR_FULL_ONES >> res_code_reg;

    clrr_channel_fmt #(.W(W)) u_fmt_green
    (
        .raw_value  (raw_green_value),
        .comp_value (raw_comp_value),
        .max_value  (max_val),
        .comp_en    (1'b1),
        .result     (green_next)
    );

    clrr_channel_fmt #(.W(W)) u_fmt_blue
    (
        .raw_value  (raw_blue_value),
        .comp_value (raw_comp_value),
        .max_value  (max_val),
        .comp_en    (1'b1),
        .result     (blue_next)
    );

    clrr_channel_fmt #(.W(W)) u_fmt_red
    (
        .raw_value  (raw_red_value),
        .comp_value (raw_comp_value),
        .max_value  (max_val),
        .comp_en    (1'b1),
        .result     (red_next)
    );

    // The compensation channel itself is reported uncompensated.
    clrr_channel_fmt #(.W(W)) u_fmt_comp
    (
        .raw_value  (raw_comp_value),
        .comp_value (raw_comp_value),
        .max_value  (max_val),
        .comp_en    (1'b0),
        .result     (comp_next)
    );

    // Results load only on a finished conversion; the host cannot write them.
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            green_reg <= `CLRR_RESULT_RESET;
            blue_reg  <= `CLRR_RESULT_RESET;
            red_reg   <= `CLRR_RESULT_RESET;
            comp_reg  <= `CLRR_RESULT_RESET;
        end
        else if (raw_valid)
        begin
            green_reg <= green_next;
            blue_reg  <= blue_next;
            red_reg   <= red_next;
            comp_reg  <= comp_next;
        end
    end

    // The resolution of the stored set is kept for checking the zero fill.
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            res_code_reg <= `CLRR_RES_CODE_RST;
        else if (raw_valid)
            res_code_reg <= resolution_rate_config;
    end

    // Top bytes carry only four data bits; the upper nibble is tied to zero.
    always_comb
    begin
        unique case (rd_addr)
            `CLRR_GREEN_LOW:  rd_data_next = green_reg[7:0];
            `CLRR_GREEN_MID:  rd_data_next = green_reg[15:8];
            `CLRR_GREEN_HIGH: rd_data_next = {`CLRR_NIBBLE_ZERO, green_reg[19:16]};
            `CLRR_BLUE_LOW:   rd_data_next = blue_reg[7:0];
            `CLRR_BLUE_MID:   rd_data_next = blue_reg[15:8];
            `CLRR_BLUE_HIGH:  rd_data_next = {`CLRR_NIBBLE_ZERO, blue_reg[19:16]};
            `CLRR_RED_LOW:    rd_data_next = red_reg[7:0];
            `CLRR_RED_MID:    rd_data_next = red_reg[15:8];
            `CLRR_RED_HIGH:   rd_data_next = {`CLRR_NIBBLE_ZERO, red_reg[19:16]};
            `CLRR_COMP_LOW:   rd_data_next = comp_reg[7:0];
            `CLRR_COMP_MID:   rd_data_next = comp_reg[15:8];
            `CLRR_COMP_HIGH:  rd_data_next = {`CLRR_NIBBLE_ZERO, comp_reg[19:16]};
            default:          rd_data_next = `CLRR_BYTE_ZERO;
        endcase
    end

    // Read data is registered so the host sees a clean byte one cycle later.
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            rd_data_reg <= `CLRR_BYTE_ZERO;
            rd_ack_reg  <= 1'b0;
        end
        else
        begin
            rd_ack_reg <= rd_req;
            if (rd_req)
                rd_data_reg <= rd_data_next;
        end
    end

    assign rd_ack           = rd_ack_reg;
    assign rd_data          = rd_data_reg;
    assign green_result     = green_reg;
    assign blue_result      = blue_reg;
    assign red_result       = red_reg;
    assign temp_comp_result = comp_reg;

    default clocking cb @(posedge clk_sys);
    endclocking

    default disable iff (rst);

    chk_green_subtract: assert property (
        raw_valid && (raw_green_value < max_val) && (raw_comp_value <= max_val)
        && (raw_green_value > raw_comp_value)
        |=> (green_reg + $past(raw_comp_value)) == $past(raw_green_value))
    else $error("Green result is not raw minus compensation.");

    chk_blue_full_scale: assert property (
        raw_valid && (raw_blue_value >= max_val)
        |=> blue_reg == $past(max_val))
    else $error("Full-scale blue raw value did not report maximum.");

    chk_red_clip_bound: assert property (
        raw_valid |=> red_reg <= $past(max_val))
    else $error("Red result exceeds the selected full scale.");

    chk_comp_lsb_aligned: assert property (
        raw_valid && (raw_comp_value < max_val)
        |=> comp_reg == $past(raw_comp_value))
    else $error("Compensation result is shifted or altered.");

    chk_upper_zero_fill: assert property (
        (res_code_reg != `CLRR_RES_CODE_RST)
        |-> ((green_reg | blue_reg | red_reg | comp_reg) & ~stored_max)
            == `CLRR_RESULT_RESET)
    else $error("Result bits set above the selected resolution.");

    chk_mid_zero_fill: assert property (
        (res_code_reg > 3'h4)
        |-> (blue_reg[19:16] == `CLRR_NIBBLE_ZERO)
            && ((red_reg[15:8] & ~stored_max[15:8]) == `CLRR_BYTE_ZERO))
    else $error("Middle result byte set above the selected resolution.");

    chk_green_high_map: assert property (
        rd_req && (rd_addr == `CLRR_GREEN_HIGH)
        |=> rd_ack && (rd_data == {`CLRR_NIBBLE_ZERO, $past(green_reg[19:16])}))
    else $error("Green top byte read back wrongly.");

    chk_blue_low_map: assert property (
        rd_req && (rd_addr == `CLRR_BLUE_LOW)
        |=> rd_ack && (rd_data == $past(blue_reg[7:0])))
    else $error("Blue low byte read back wrongly.");

    chk_red_mid_map: assert property (
        rd_req && (rd_addr == `CLRR_RED_MID)
        |=> rd_ack && (rd_data == $past(red_reg[15:8])))
    else $error("Red middle byte read back wrongly.");

    chk_comp_mid_map: assert property (
        rd_req && (rd_addr == `CLRR_COMP_MID)
        |=> rd_data == $past(comp_reg[15:8]))
    else $error("Compensation middle byte read back wrongly.");

    chk_results_hold: assert property (
        !raw_valid |=> $stable(green_reg) && $stable(blue_reg)
                       && $stable(red_reg) && $stable(comp_reg))
    else $error("A result changed without a conversion.");

    chk_green_floor: assert property (
        raw_valid && (raw_green_value < max_val) && (raw_green_value <= raw_comp_value)
        |=> green_reg == `CLRR_RESULT_RESET)
    else $error("Green result wrapped instead of flooring at zero.");

    // The same arithmetic is checked on every colour channel, not only on green.
    chk_blue_subtract: assert property (
        raw_valid && (raw_blue_value < max_val) && (raw_comp_value <= max_val)
        && (raw_blue_value > raw_comp_value)
        |=> (blue_reg + $past(raw_comp_value)) == $past(raw_blue_value))
    else $error("Blue result is not raw minus compensation.");

    chk_red_subtract: assert property (
        raw_valid && (raw_red_value < max_val) && (raw_comp_value <= max_val)
        && (raw_red_value > raw_comp_value)
        |=> (red_reg + $past(raw_comp_value)) == $past(raw_red_value))
    else $error("Red result is not raw minus compensation.");

    chk_green_full_scale: assert property (
        raw_valid && (raw_green_value >= max_val)
        |=> green_reg == $past(max_val))
    else $error("Full-scale green raw value did not report maximum.");

    chk_red_full_scale: assert property (
        raw_valid && (raw_red_value >= max_val)
        |=> red_reg == $past(max_val))
    else $error("Full-scale red raw value did not report maximum.");

    chk_comp_full_clip: assert property (
        raw_valid && (raw_comp_value >= max_val)
        |=> comp_reg == $past(max_val))
    else $error("Compensation result not clipped to full scale.");

    chk_green_clip_bound: assert property (
        raw_valid |=> green_reg <= $past(max_val))
    else $error("Green result exceeds the selected full scale.");

    chk_blue_clip_bound: assert property (
        raw_valid |=> blue_reg <= $past(max_val))
    else $error("Blue result exceeds the selected full scale.");

    chk_comp_clip_bound: assert property (
        raw_valid |=> comp_reg <= $past(max_val))
    else $error("Compensation result exceeds the selected full scale.");

    chk_blue_floor: assert property (
        raw_valid && (raw_blue_value < max_val) && (raw_blue_value <= raw_comp_value)
        |=> blue_reg == `CLRR_RESULT_RESET)
    else $error("Blue result wrapped instead of flooring at zero.");

    chk_red_floor: assert property (
        raw_valid && (raw_red_value < max_val) && (raw_red_value <= raw_comp_value)
        |=> red_reg == `CLRR_RESULT_RESET)
    else $error("Red result wrapped instead of flooring at zero.");

    // Read port: each mapped byte, the zero top nibbles and the unmapped holes.
    chk_green_low_map: assert property (
        rd_req && (rd_addr == `CLRR_GREEN_LOW)
        |=> rd_ack && (rd_data == $past(green_reg[7:0])))
    else $error("Green low byte read back wrongly.");

    chk_green_mid_map: assert property (
        rd_req && (rd_addr == `CLRR_GREEN_MID)
        |=> rd_ack && (rd_data == $past(green_reg[15:8])))
    else $error("Green middle byte read back wrongly.");

    chk_blue_mid_map: assert property (
        rd_req && (rd_addr == `CLRR_BLUE_MID)
        |=> rd_ack && (rd_data == $past(blue_reg[15:8])))
    else $error("Blue middle byte read back wrongly.");

    chk_blue_high_map: assert property (
        rd_req && (rd_addr == `CLRR_BLUE_HIGH)
        |=> rd_ack && (rd_data == {`CLRR_NIBBLE_ZERO, $past(blue_reg[19:16])}))
    else $error("Blue top byte read back wrongly.");

    chk_red_low_map: assert property (
        rd_req && (rd_addr == `CLRR_RED_LOW)
        |=> rd_ack && (rd_data == $past(red_reg[7:0])))
    else $error("Red low byte read back wrongly.");

    chk_red_high_map: assert property (
        rd_req && (rd_addr == `CLRR_RED_HIGH)
        |=> rd_ack && (rd_data == {`CLRR_NIBBLE_ZERO, $past(red_reg[19:16])}))
    else $error("Red top byte read back wrongly.");

    chk_comp_low_map: assert property (
        rd_req && (rd_addr == `CLRR_COMP_LOW)
        |=> rd_ack && (rd_data == $past(comp_reg[7:0])))
    else $error("Compensation low byte read back wrongly.");

    chk_comp_high_map: assert property (
        rd_req && (rd_addr == `CLRR_COMP_HIGH)
        |=> rd_ack && (rd_data == {`CLRR_NIBBLE_ZERO, $past(comp_reg[19:16])}))
    else $error("Compensation top byte read back wrongly.");

    chk_top_nibble_zero: assert property (
        rd_req && ((rd_addr == `CLRR_GREEN_HIGH) || (rd_addr == `CLRR_BLUE_HIGH)
                   || (rd_addr == `CLRR_RED_HIGH) || (rd_addr == `CLRR_COMP_HIGH))
        |=> rd_ack && (rd_data[7:4] == `CLRR_NIBBLE_ZERO))
    else $error("Upper nibble of a top byte is not zero.");

    chk_unmapped_zero: assert property (
        rd_req && ((rd_addr < `CLRR_GREEN_LOW) || (rd_addr > `CLRR_COMP_HIGH))
        |=> rd_ack && (rd_data == `CLRR_BYTE_ZERO))
    else $error("Unmapped address did not read as zero.");

    // Reset is no disable here, because the cleared values are what is checked.
    chk_reset_clear: assert property (disable iff (1'b0)
        rst |=> (green_reg == `CLRR_RESULT_RESET) && (blue_reg == `CLRR_RESULT_RESET)
                && (red_reg == `CLRR_RESULT_RESET) && (comp_reg == `CLRR_RESULT_RESET))
    else $error("A result is not zero after reset.");

    cov_full_scale: cover property (raw_valid && (raw_red_value >= max_val));
    cov_underflow: cover property (raw_valid && (raw_blue_value < raw_comp_value));
    cov_min_res: cover property (raw_valid && (resolution_rate_config == 3'h7));
    cov_read_comp: cover property (rd_req && (rd_addr == `CLRR_COMP_HIGH) ##1 rd_ack);

endmodule // clrr_result_regs

// ---- clrr_params.svh ----
// Constants for the colour light result register block.
// Summary of operation
// - Each colour result equals its raw value minus the compensation result.
// - A full-scale raw colour value reports maximum and skips the subtraction.
// - Every result is clipped to two to the resolution minus one, unsigned.
// - Results stay LSB-aligned whatever resolution is selected.
// - Upper byte zero at 16 bits or fewer; middle byte bits above the resolution zero below 16 bits.
// - Green result sits at 07, 08 and 09, low byte first.
// - Bits seven to four of each top byte always read zero.
// - Blue result sits at 0A, 0B and 0C, low byte first.
// - Red result sits at 0D, 0E and 0F, low byte first.
// - Raw compensation result sits at 10, 11 and 12, same formatting.
// - All result bytes are read-only and hold zero after reset.
`ifndef CLRR_PARAMS_SVH
`define CLRR_PARAMS_SVH

`define CLRR_GREEN_LOW   8'h07
`define CLRR_GREEN_MID   8'h08
`define CLRR_GREEN_HIGH  8'h09
`define CLRR_BLUE_LOW    8'h0a
`define CLRR_BLUE_MID    8'h0b
`define CLRR_BLUE_HIGH   8'h0c
`define CLRR_RED_LOW     8'h0d
`define CLRR_RED_MID     8'h0e
`define CLRR_RED_HIGH    8'h0f
`define CLRR_COMP_LOW    8'h10
`define CLRR_COMP_MID    8'h11
`define CLRR_COMP_HIGH   8'h12

`define CLRR_RESULT_RESET 20'h0_0000
`define CLRR_FULL_ONES    20'hf_ffff
`define CLRR_BYTE_ZERO    8'h00
`define CLRR_NIBBLE_ZERO  4'h0
`define CLRR_RES_CODE_RST 3'h0
`define CLRR_MID_LSB      8
`define CLRR_HIGH_LSB     16

`endif

// ---- clrr_pkg.sv ----
// Types shared by the colour light result register block.
package clrr_pkg;

    typedef logic [19:0] clrr_result_t;
    typedef logic [2:0]  clrr_res_code_t;

endpackage

// ---- clrr_channel_fmt.sv ----
// One channel formatter: compensation, full-scale override and clipping.
`timescale 1ns/1ps
`include "clrr_params.svh"

module clrr_channel_fmt
    import clrr_pkg::*;
#(
    parameter int W = 20
)
(
    // Sample inputs
    input  wire logic [W-1:0] raw_value,
    input  wire logic [W-1:0] comp_value,
    input  wire logic [W-1:0] max_value,
    input  wire logic         comp_en,
    // Formatted result
    output logic      [W-1:0] result
);

    logic [W-1:0] raw_clip;
    logic [W-1:0] comp_clip;
    logic         full_scale;

    // The raw value may come from a wider converter than the chosen resolution.
    assign full_scale = (raw_value >= max_value);
    assign raw_clip   = full_scale ? max_value : raw_value;
    assign comp_clip  = (comp_value > max_value) ? max_value : comp_value;

    always_comb
    begin
        if (!comp_en)
            result = raw_clip;
        else if (full_scale)
            result = max_value;
        else if (raw_clip > comp_clip)
            result = raw_clip - comp_clip;
        else
            result = '0;
    end

endmodule // clrr_channel_fmt

// ---- clrr_host_model.sv ----
// Host-side model that reads the result registers through the read port.
`timescale 1ns/1ps

module clrr_host_model
(
    // Clock
    input  wire logic       clk_sys,
    // Read port
    output logic            rd_req,
    output logic [7:0]      rd_addr,
    input  wire logic       rd_ack,
    input  wire logic [7:0] rd_data
);

    initial
    begin
        rd_req  = 1'b0;
        rd_addr = 8'h00;
    end

    // The address is inverted once the request is gone, so late sampling shows up.
    task automatic read(input logic [7:0] addr, output logic [7:0] data, output bit ok);
        ok   = 1'b0;
        data = 8'h00;
        @(posedge clk_sys);
        #1;
        rd_req  = 1'b1;
        rd_addr = addr;
        @(posedge clk_sys);
        #1;
        rd_req  = 1'b0;
        rd_addr = ~addr;
        for (int i = 0; i < 4 && !ok; i++)
        begin
            if (rd_ack === 1'b1)
            begin
                data = rd_data;
                ok   = 1'b1;
            end
            else
            begin
                @(posedge clk_sys);
                #1;
            end
        end
    endtask

endmodule // clrr_host_model

// ---- tb_top.sv ----
// Self-checking testbench for the result register block.
`timescale 1ns/1ps

module tb_top
    import clrr_pkg::*;
;

    logic         clk_sys = 1'b0;
    logic         rst;
    logic         raw_valid;
    clrr_result_t raw_g;
    clrr_result_t raw_b;
    clrr_result_t raw_r;
    clrr_result_t raw_c;
    logic [2:0]   res_code;
    logic         rd_req;
    logic [7:0]   rd_addr;
    logic         rd_ack;
    logic [7:0]   rd_data;
    clrr_result_t res_v [4];
    int           failures = 0;
    int           num_checks = 0;

    always #5 clk_sys = ~clk_sys;

    clrr_result_regs i_clrr_result_regs (.clk_sys(clk_sys), .rst(rst), .raw_valid(raw_valid),
        .raw_green_value(raw_g), .raw_blue_value(raw_b), .raw_red_value(raw_r),
        .raw_comp_value(raw_c), .resolution_rate_config(res_code), .rd_req(rd_req),
        .rd_addr(rd_addr), .rd_ack(rd_ack), .rd_data(rd_data), .green_result(res_v[0]),
        .blue_result(res_v[1]), .red_result(res_v[2]), .temp_comp_result(res_v[3]));

    clrr_host_model i_clrr_host_model (.clk_sys(clk_sys), .rd_req(rd_req), .rd_addr(rd_addr),
        .rd_ack(rd_ack), .rd_data(rd_data));

    task automatic wrap_up();
        $display("checks=%0d failures=%0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic check(string what, logic [19:0] seen, logic [19:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("MISMATCH %s expected=%h seen=%h", what, exp, seen);
        end
    endtask

    // Expected value worked out from the formatting rules, not from the design.
    function automatic clrr_result_t fmt(clrr_result_t raw, clrr_result_t comp, int code, bit col);
        clrr_result_t mx;
        clrr_result_t c;
        mx = 20'hf_ffff >> code;
        c  = (comp > mx) ? mx : comp;
        if (!col)
            return c;
        if (raw >= mx)
            return mx;
        return (raw > c) ? raw - c : 20'h0_0000;
    endfunction

    task automatic read_chk(logic [7:0] a, logic [7:0] exp);
        logic [7:0] d;
        bit         ok;
        i_clrr_host_model.read(a, d, ok);
        if (!ok)
        begin
            failures++;
            wrap_up();
        end
        check($sformatf("byte %h", a), {12'h000, d}, {12'h000, exp});
    endtask

    task automatic read_all(clrr_result_t v [4]);
        logic [23:0] w;
        for (int ch = 0; ch < 4; ch++)
        begin
            w = {4'h0, v[ch]};
            for (int k = 0; k < 3; k++)
                read_chk(8'h07 + 8'(3 * ch + k), w[8*k +: 8]);
        end
    endtask

    task automatic load(clrr_result_t g, clrr_result_t b, clrr_result_t r, clrr_result_t c,
                        logic [2:0] code);
        @(posedge clk_sys);
        #1;
        raw_valid = 1'b1;
        raw_g     = g;
        raw_b     = b;
        raw_r     = r;
        raw_c     = c;
        res_code  = code;
        @(posedge clk_sys);
        #1;
        raw_valid = 1'b0;
    endtask

    initial
    begin
        clrr_result_t ex [4];
        clrr_result_t zero4 [4];
        logic [7:0]   holes [4];
        clrr_result_t pick [3];
        zero4 = '{default: 20'h0_0000};
        holes = '{8'h00, 8'h06, 8'h13, 8'hff};
        rst = 1'b1;
        raw_valid = 1'b0;
        {raw_g, raw_b, raw_r, raw_c} = '0;
        res_code = 3'h0;
        repeat (12) @(posedge clk_sys);
        #1;
        rst = 1'b0;
        read_all(zero4);
        foreach (holes[i])
            read_chk(holes[i], 8'h00);
        for (int code = 0; code < 8; code++)
        begin
            // Each channel takes each role in turn: in range, at or over full scale, below comp.
            pick = '{20'h9_8765 >> code, 20'hf_ffff, 20'h0_0010};
            load(pick[code % 3], pick[(code + 1) % 3], pick[(code + 2) % 3],
                 (code == 7) ? 20'hf_ffff : 20'h0_1234 >> (code / 2), 3'(code));
            ex[0] = fmt(raw_g, raw_c, code, 1'b1);
            ex[1] = fmt(raw_b, raw_c, code, 1'b1);
            ex[2] = fmt(raw_r, raw_c, code, 1'b1);
            ex[3] = fmt(raw_c, raw_c, code, 1'b0);
            for (int ch = 0; ch < 4; ch++)
                check($sformatf("result %0d", ch), res_v[ch], ex[ch]);
            read_all(ex);
        end
        // A second reset in mid-run must clear every stored result.
        @(posedge clk_sys);
        #1;
        rst = 1'b1;
        @(posedge clk_sys);
        #1;
        rst = 1'b0;
        read_all(zero4);
        wrap_up();
    end

endmodule // tb_top
